// File: sbt_pkg.sv
// shared constants and types for the sensor serial bit timing block
`default_nettype none
package sbt_pkg;
    // reference clock rate and conversion limits per temperature resolution
    localparam int REF_MHZ = 40;
    localparam int T14_US = 50000;
    localparam int T13_US = 25000;
    localparam int T12_US = 13000;
    localparam int T11_US = 7000;
    // longest times round down; these are exact at 40 MHz
    localparam int C14_CYC = T14_US * REF_MHZ;
    localparam int C13_CYC = T13_US * REF_MHZ;
    localparam int C12_CYC = T12_US * REF_MHZ;
    localparam int C11_CYC = T11_US * REF_MHZ;
    localparam int CNT_W = 21;
    // resolution select codes
    localparam logic [1:0] RES_14 = 2'h0;
    localparam logic [1:0] RES_12 = 2'h1;
    localparam logic [1:0] RES_13 = 2'h2;
    localparam logic [1:0] RES_11 = 2'h3;
    // bus address and commands
    localparam logic [6:0] DEV_ADDR = 7'h40;
    localparam logic [7:0] CMD_HOLD = 8'he3;
    localparam logic [7:0] CMD_POLL = 8'hf3;
    // bit counter positions within a byte frame
    localparam logic [3:0] BIT_FIRST = 4'h1;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    // status bits of the result word
    localparam logic KIND_TEMP = 1'b0;
    localparam logic SPARE_BIT = 1'b0;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_ADDR = 4'h2,
        ST_CMD = 4'h4,
        ST_TX = 4'h8
    } sbt_state_t;
    typedef struct packed {
        logic [13:0] value;
        logic kind;
        logic spare;
    } sbt_result_t;
endpackage
`default_nettype wire

// File: sbt_conv_timer.sv
// conversion timer: busy window sized by the selected resolution
`timescale 1ns/1ps
`default_nettype none
module sbt_conv_timer #(
    parameter int C14 = sbt_pkg::C14_CYC,
    parameter int C13 = sbt_pkg::C13_CYC,
    parameter int C12 = sbt_pkg::C12_CYC,
    parameter int C11 = sbt_pkg::C11_CYC,
    parameter int CW = sbt_pkg::CNT_W
)(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [1:0] res_sel,
    output logic busy,
    output logic done
);
    logic [CW-1:0] cnt;
    logic [CW-1:0] lim;
    logic [CW-1:0] next_cnt;
    logic [CW-1:0] next_lim;
    logic next_busy;
    logic next_done;

    // cycles allowed for one conversion at a resolution
    function automatic logic [CW-1:0] limit(input logic [1:0] r);
        case (r)
            sbt_pkg::RES_13: limit = CW'(C13);
            sbt_pkg::RES_12: limit = CW'(C12);
            sbt_pkg::RES_11: limit = CW'(C11);
            default: limit = CW'(C14);
        endcase
    endfunction

    // count the window; a start during a running conversion is ignored
    always_comb
    begin
        next_cnt = cnt;
        next_lim = lim;
        next_busy = busy;
        next_done = 1'b0;
        if (busy)
        begin
            if (cnt == lim - CW'(1))
            begin
                next_busy = 1'b0;
                next_done = 1'b1;
                next_cnt = '0;
            end
            else
            begin
                next_cnt = cnt + CW'(1);
            end
        end
        else if (start)
        begin
            next_busy = 1'b1;
            next_cnt = '0;
            next_lim = limit(res_sel);
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            cnt <= '0;
            lim <= limit(sbt_pkg::RES_14);
            busy <= 1'b0;
            done <= 1'b0;
        end
        else
        begin
            cnt <= next_cnt;
            lim <= next_lim;
            busy <= next_busy;
            done <= next_done;
        end
    end

    busy_bound_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        busy |-> cnt < lim)
        else $error("conversion ran past its limit");
    start_busy_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!busy && start) |=> busy && cnt == '0)
        else $error("start did not open a conversion");
    done_edge_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        done |-> !busy && $past(busy))
        else $error("done pulse without end of conversion");
endmodule
`default_nettype wire

// File: sbt_serial_top.sv
// serial interface of the sensor with conversion timing and clock stretch
`timescale 1ns/1ps
`default_nettype none
module sbt_serial_top #(
    parameter int C14 = sbt_pkg::C14_CYC,
    parameter int C13 = sbt_pkg::C13_CYC,
    parameter int C12 = sbt_pkg::C12_CYC,
    parameter int C11 = sbt_pkg::C11_CYC
)(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic [1:0] res_sel,
    input wire logic [13:0] temp_raw,
    output logic sda_out,
    output logic sda_oe_n,
    output logic scl_out,
    output logic scl_oe_n,
    output logic conv_busy
);
    // reference domain state
    logic scl_m, scl_s, req_m, req_s, req_d, hold_mode, have_res, rdy, pin_low;
    logic conv_start, conv_done, next_hold_mode, next_have_res, next_rdy, next_scl_oe_n;
    sbt_pkg::sbt_result_t res_q, next_res_q;
    // link domain state
    logic srst_m, srst_s, rdy_m, rdy_s, start_tgl, start_ack, start;
    sbt_pkg::sbt_state_t st, next_st;
    logic [3:0] cnt, next_cnt;
    logic [7:0] sr, next_sr, byte_in;
    logic hi_byte, drive, req, cmd_hold;
    logic next_hi_byte, next_drive, next_req, next_cmd_hold, next_start_ack;

    sbt_conv_timer #(
        .C14(C14), .C13(C13), .C12(C12), .C11(C11), .CW(sbt_pkg::CNT_W)
    ) i_sbt_conv_timer (
        .ref_clk(ref_clk), .rst_n(rst_n), .start(conv_start),
        .res_sel(res_sel), .busy(conv_busy), .done(conv_done)
    );
    // level and toggle crossings from the link into the reference domain
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            req_m <= 1'b0;
            req_s <= 1'b0;
            req_d <= 1'b0;
            pin_low <= 1'b0;
        end
        else
        begin
            scl_m <= scl_in;
            scl_s <= scl_m;
            req_m <= req;
            req_s <= req_m;
            req_d <= req_s;
            pin_low <= 1'b0;
        end
    end

    assign conv_start = req_s ^ req_d;
    assign sda_out = pin_low;
    assign scl_out = pin_low;
    // mode is read only on the request pulse, long after it settled
    always_comb
    begin
        next_hold_mode = hold_mode;
        next_have_res = have_res;
        next_res_q = res_q;
        if (conv_start && !conv_busy)
        begin
            next_hold_mode = cmd_hold;
            next_have_res = 1'b0;
        end
        if (conv_done)
        begin
            next_have_res = 1'b1;
            next_res_q.value = temp_raw;
            next_res_q.kind = sbt_pkg::KIND_TEMP;
            next_res_q.spare = sbt_pkg::SPARE_BIT;
        end
        next_rdy = next_have_res && !conv_busy;
        // pull the clock only once the master has let it fall
        next_scl_oe_n = !(conv_busy && hold_mode && !scl_s);
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            hold_mode <= 1'b0;
            have_res <= 1'b0;
            res_q <= '0;
            rdy <= 1'b0;
            scl_oe_n <= 1'b1;
        end
        else
        begin
            hold_mode <= next_hold_mode;
            have_res <= next_have_res;
            res_q <= next_res_q;
            rdy <= next_rdy;
            scl_oe_n <= next_scl_oe_n;
        end
    end

    // start condition: data falls while the clock is high; no clock edge
    // comes with it, so the data edge itself marks it
    always_ff @(negedge sda_in or negedge rst_n)
    begin
        if (!rst_n)
            start_tgl <= 1'b0;
        else if (scl_in)
            start_tgl <= ~start_tgl;
    end

    // reset and ready levels into the link domain, two stages each
    always_ff @(posedge scl_in)
    begin
        srst_m <= rst_n;
        srst_s <= srst_m;
        rdy_m <= rdy;
        rdy_s <= rdy_m;
    end

    assign start = start_tgl ^ start_ack;
    assign byte_in = {sr[6:0], sda_in};
    // byte engine; every step waits for a clock edge, so no rate limit
    always_comb
    begin
        next_st = st;
        next_cnt = cnt;
        next_sr = sr;
        next_hi_byte = hi_byte;
        next_drive = 1'b0;
        next_req = req;
        next_cmd_hold = cmd_hold;
        next_start_ack = start_ack;
        if (start)
        begin
            next_start_ack = start_tgl;
            next_st = sbt_pkg::ST_ADDR;
            next_sr = byte_in;
            next_cnt = sbt_pkg::BIT_FIRST;
        end
        else
        begin
            case (st)
                sbt_pkg::ST_ADDR, sbt_pkg::ST_CMD:
                begin
                    if (cnt < sbt_pkg::BIT_LAST)
                    begin
                        next_sr = byte_in;
                        next_cnt = cnt + 4'h1;
                    end
                    else if (cnt == sbt_pkg::BIT_LAST)
                    begin
                        next_sr = byte_in;
                        next_cnt = sbt_pkg::BIT_ACK;
                        if (st == sbt_pkg::ST_ADDR)
                            next_drive = (byte_in[7:1] == sbt_pkg::DEV_ADDR)
                                && (!byte_in[0] || rdy_s);
                        else
                            next_drive = (byte_in == sbt_pkg::CMD_HOLD)
                                || (byte_in == sbt_pkg::CMD_POLL);
                    end
                    else if (!drive)
                        next_st = sbt_pkg::ST_IDLE;
                    else if (st == sbt_pkg::ST_CMD)
                    begin
                        next_req = ~req;
                        next_cmd_hold = (sr == sbt_pkg::CMD_HOLD);
                        next_st = sbt_pkg::ST_IDLE;
                    end
                    else if (sr[0])
                    begin
                        next_st = sbt_pkg::ST_TX;
                        next_sr = res_q[15:8];
                        next_hi_byte = 1'b1;
                        next_cnt = '0;
                        next_drive = ~res_q[15];
                    end
                    else
                    begin
                        next_st = sbt_pkg::ST_CMD;
                        next_cnt = '0;
                    end
                end
                sbt_pkg::ST_TX:
                begin
                    if (cnt < sbt_pkg::BIT_LAST)
                    begin
                        next_sr = {sr[6:0], 1'b0};
                        next_drive = ~sr[6];
                        next_cnt = cnt + 4'h1;
                    end
                    else if (cnt == sbt_pkg::BIT_LAST)
                        next_cnt = sbt_pkg::BIT_ACK; // release for master ack
                    else if (!sda_in && hi_byte)
                    begin
                        next_sr = res_q[7:0];
                        next_hi_byte = 1'b0;
                        next_cnt = '0;
                        next_drive = ~res_q[7];
                    end
                    else
                        next_st = sbt_pkg::ST_IDLE; // no checksum byte follows
                end
                default:
                begin
                    next_st = sbt_pkg::ST_IDLE;
                    next_cnt = '0;
                end
            endcase
        end
    end

    always_ff @(posedge scl_in)
    begin
        if (!srst_s)
        begin
            st <= sbt_pkg::ST_IDLE;
            cnt <= '0;
            sr <= '0;
            hi_byte <= 1'b0;
            drive <= 1'b0;
            req <= 1'b0;
            cmd_hold <= 1'b0;
            start_ack <= 1'b0;
        end
        else
        begin
            st <= next_st;
            cnt <= next_cnt;
            sr <= next_sr;
            hi_byte <= next_hi_byte;
            drive <= next_drive;
            req <= next_req;
            cmd_hold <= next_cmd_hold;
            start_ack <= next_start_ack;
        end
    end
    // data pin moves only on the falling edge and holds to the next one
    always_ff @(negedge scl_in or negedge rst_n)
    begin
        if (!rst_n)
            sda_oe_n <= 1'b1;
        else
            sda_oe_n <= ~drive;
    end

    capture_a: assert property (@(posedge scl_in) disable iff (!srst_s)
        (st == sbt_pkg::ST_ADDR && cnt < sbt_pkg::BIT_LAST && !start)
        |=> sr[0] == $past(sda_in))
        else $error("address bit not taken on rising clock");
    nack_busy_a: assert property (@(posedge scl_in) disable iff (!srst_s)
        (st == sbt_pkg::ST_ADDR && cnt == sbt_pkg::BIT_LAST && !start
        && sda_in && !rdy_s) |=> !drive ##1 (st == sbt_pkg::ST_IDLE))
        else $error("read header acknowledged while busy");
    tx_bit_a: assert property (@(posedge scl_in) disable iff (!srst_s)
        (st == sbt_pkg::ST_TX && cnt < sbt_pkg::BIT_ACK && !start)
        |-> sda_oe_n == sr[7])
        else $error("sent bit differs from pin");
    addr_quiet_a: assert property (@(posedge scl_in) disable iff (!srst_s)
        (st == sbt_pkg::ST_ADDR && cnt > sbt_pkg::BIT_FIRST
        && cnt < sbt_pkg::BIT_LAST) |-> sda_oe_n)
        else $error("data pulled during header");
    cmd_req_a: assert property (@(posedge scl_in) disable iff (!srst_s)
        (st == sbt_pkg::ST_CMD && cnt == sbt_pkg::BIT_ACK && drive && !start)
        |=> req != $past(req))
        else $error("accepted command did not request conversion");
    stretch_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !scl_oe_n |-> $past(conv_busy) && hold_mode)
        else $error("clock held without a stretched conversion");
    release_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $fell(conv_busy) |=> scl_oe_n ##1 rdy)
        else $error("clock not released at conversion end");
    status_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        have_res |-> res_q[1:0] == {sbt_pkg::KIND_TEMP, sbt_pkg::SPARE_BIT})
        else $error("status bits of result wrong");
endmodule
`default_nettype wire

// File: sbt_master_model.sv
// master model for the two-wire link: pulls the lines low or releases them
`timescale 1ns/1ps
`default_nettype none
module sbt_master_model (
    input wire logic scl,
    input wire logic sda,
    output logic scl_low,
    output logic sda_low
);
    int q = 12; // quarter of the link period, 48 ns nominal
    logic hung = 1'b0;
    initial
    begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    // a stretched clock is waited for, but never forever: a stuck pull shows up
    task automatic wait_high();
        int n;
        n = 0;
        while (scl !== 1'b1 && n < 20000)
        begin
            #1;
            n++;
        end
        if (n >= 20000)
            hung = 1'b1;
    endtask
    // one bit: data moves only while the clock is low, sampled mid-high
    task automatic bit_x(input logic b, output logic r);
        #q;
        sda_low = !b;
        #q;
        scl_low = 1'b0;
        wait_high();
        #q;
        r = sda;
        #q;
        scl_low = 1'b1;
    endtask
    // clock pulses with data high, so no start is ever seen
    task automatic pulses(input int n);
        repeat (n)
        begin
            #(2*q) scl_low = 1'b1;
            #(2*q) scl_low = 1'b0;
        end
    endtask
    task automatic start();
        sda_low = 1'b0;
        #q;
        scl_low = 1'b0;
        wait_high();
        #q;
        sda_low = 1'b1;
        #q;
        scl_low = 1'b1;
    endtask
    task automatic stop();
        #q sda_low = 1'b1;
        #q scl_low = 1'b0;
        wait_high();
        #q sda_low = 1'b0;
        #q;
    endtask
    task automatic wr(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_x(d[i], r);
        bit_x(1'b1, r);
        ack = !r;
    endtask
    task automatic rd(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_x(1'b1, r);
            d[i] = r;
        end
        bit_x(!ack, r);
    endtask
endmodule
`default_nettype wire

// File: tb_sbt_serial_top.sv
// testbench for the serial interface, conversion timing and clock stretch
`timescale 1ns/1ps
`default_nettype none
module tb_sbt_serial_top;
    localparam int L14 = 200;
    localparam int L13 = 100;
    localparam int L12 = 52;
    localparam int L11 = 28;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] res_sel = sbt_pkg::RES_14;
    logic [13:0] temp_raw = 14'h0;
    logic sda_out, sda_oe_n, scl_out, scl_oe_n, conv_busy;
    logic m_scl_low, m_sda_low;
    logic busy_q = 1'b0;
    int errors = 0;
    int total_checks = 0;
    int busy_len = 0;
    int stretch_cnt = 0;
    // pull-ups give the high level; any party pulling wins
    wire logic scl = !((scl_oe_n === 1'b0) || m_scl_low);
    wire logic sda = !((sda_oe_n === 1'b0) || m_sda_low);
    initial
    begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    sbt_serial_top #(.C14(L14), .C13(L13), .C12(L12), .C11(L11)) i_sbt_serial_top (
        .ref_clk(ref_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
        .res_sel(res_sel), .temp_raw(temp_raw), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
        .conv_busy(conv_busy));
    sbt_master_model i_sbt_master_model (
        .scl(scl), .sda(sda), .scl_low(m_scl_low), .sda_low(m_sda_low));
    // busy length and stretch cycles are counted apart from the link traffic
    always @(posedge ref_clk)
    begin
        busy_q <= conv_busy;
        if (conv_busy === 1'b1 && busy_q !== 1'b1)
            busy_len <= 1;
        else if (conv_busy === 1'b1)
            busy_len <= busy_len + 1;
        if (conv_busy === 1'b1 && scl_oe_n === 1'b0)
            stretch_cnt <= stretch_cnt + 1;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    function automatic int limit(input logic [1:0] r);
        case (r)
            sbt_pkg::RES_14: return L14;
            sbt_pkg::RES_13: return L13;
            sbt_pkg::RES_12: return L12;
            default: return L11;
        endcase
    endfunction
    task automatic t_reset();
        check(16'(sda_oe_n), 16'h1);
        check(16'(scl_oe_n), 16'h1);
        check(16'(conv_busy), 16'h0);
        check(16'({sda_out, scl_out}), 16'h0);
        $display("test reset done");
    endtask
    // wrong address, read with no result, unknown command: all refused
    task automatic t_refuse();
        logic a;
        i_sbt_master_model.start();
        i_sbt_master_model.wr(8'h82, a);
        check(16'(a), 16'h0);
        i_sbt_master_model.start();
        i_sbt_master_model.wr({sbt_pkg::DEV_ADDR, 1'b1}, a);
        check(16'(a), 16'h0);
        i_sbt_master_model.start();
        i_sbt_master_model.wr({sbt_pkg::DEV_ADDR, 1'b0}, a);
        check(16'(a), 16'h1);
        i_sbt_master_model.wr(8'he5, a);
        check(16'(a), 16'h0);
        i_sbt_master_model.stop();
        check(16'(conv_busy), 16'h0);
        $display("test refuse done");
    endtask
    // one conversion, polled or stretched, then the two result bytes
    task automatic t_conv(input logic [1:0] r, input logic [13:0] v, input logic hold);
        logic a;
        logic [7:0] hi, lo;
        int n, s0;
        @(posedge ref_clk);
        res_sel <= r;
        temp_raw <= v;
        s0 = stretch_cnt;
        n = 0;
        i_sbt_master_model.start();
        i_sbt_master_model.wr({sbt_pkg::DEV_ADDR, 1'b0}, a);
        check(16'(a), 16'h1);
        i_sbt_master_model.wr(hold ? sbt_pkg::CMD_HOLD : sbt_pkg::CMD_POLL, a);
        check(16'(a), 16'h1);
        // a stretch may only begin while the clock is low: keep it low long enough to be seen
        if (hold)
            repeat (10) @(posedge ref_clk);
        do
        begin
            i_sbt_master_model.start();
            i_sbt_master_model.wr({sbt_pkg::DEV_ADDR, 1'b1}, a);
            n++;
        end
        while (!a && n < 60);
        check(16'(a), 16'h1);
        if (!a)
            test_done();
        // a slow link polls only after the limit has passed, so its first header is taken
        if (!hold)
            check(16'(n > 1), 16'(i_sbt_master_model.q < 100));
        else
        begin
            check(16'(stretch_cnt > s0), 16'h1);
            check(16'(n), 16'h1);
        end
        i_sbt_master_model.rd(1'b1, hi);
        i_sbt_master_model.rd(1'b0, lo);
        i_sbt_master_model.stop();
        check(16'(hi), 16'(v[13:6]));
        check(16'(lo), 16'({v[5:0], sbt_pkg::KIND_TEMP, sbt_pkg::SPARE_BIT}));
        check(16'(busy_len), 16'(limit(r)));
        check(16'({conv_busy, scl_oe_n}), 16'h1);
        $display("test conversion res %0d hold %0d done", r, hold);
    endtask
    initial
    begin
        fork
            i_sbt_master_model.pulses(4);
            repeat (10) @(posedge ref_clk);
        join
        rst_n <= 1'b1;
        i_sbt_master_model.pulses(4);
        t_reset();
        t_refuse();
        for (int r = 0; r < 4; r++)
        begin
            t_conv(2'(r), 14'h2a5c ^ 14'(r * 14'h1111), 1'b0);
            t_conv(2'(r), 14'h15a3 + 14'(r), 1'b1);
        end
        // a very slow serial clock must still work: the link logic is static
        i_sbt_master_model.q = 400;
        t_conv(sbt_pkg::RES_11, 14'h3fff, 1'b0);
        i_sbt_master_model.q = 12;
        check(16'(i_sbt_master_model.hung), 16'h0);
        test_done();
    end
    initial
    begin
        #2000000;
        errors++;
        $display("MISMATCH at %0t: run too long", $time);
        test_done();
    end
endmodule
`default_nettype wire
